// *** logic/spot_pin_sync.v ***
/*
  three-flop synchroniser with agreement filter for a group of pins.
  assumes pins are asynchronous to clk; the accepted level changes only
  once the second and third flops agree.
*/
`timescale 1ns/1ps
`include "spot_defs.vh"

module spot_pin_sync #(
  parameter WIDTH = 4
) (
  input wire clk,
  input wire rst_n,
  input wire [WIDTH-1:0] pin_async,
  output reg [WIDTH-1:0] pin_level_q
);

  reg [WIDTH-1:0] s1_q;
  reg [WIDTH-1:0] s2_q;
  reg [WIDTH-1:0] s3_q;
  integer i;

  // ----------------------------------------------------------------
  // capture chain and agreement
  // ----------------------------------------------------------------
  // first flop feeds only the second, to keep metastability contained
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= {WIDTH{1'b0}};
      s2_q <= {WIDTH{1'b0}};
      s3_q <= {WIDTH{1'b0}};
      pin_level_q <= {WIDTH{1'b0}};
    end else begin
      s1_q <= pin_async;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (i = 0; i < WIDTH; i = i + 1) begin
        if (s2_q[i] == s3_q[i]) begin
          pin_level_q[i] <= s3_q[i];
        end
      end
    end
  end

endmodule // spot_pin_sync

// *** logic/spot_synth_override.v ***
/*
  synthesizer pin override and oscillator trim control.
  holds the override and trim registers on the control-port register
  interface, picks pin or register control, and tracks calibration status.
  assumes the serial control port has been decoded to a parallel byte
  access on clk, and that the calibration engine runs on clk as well.
*/
// Operation
// - select 0: pins drive synthesizer controls
// - select 1: register fields drive synthesizer controls
// - second selector bits 5:4 off,/1,/2,/4
// - pin mode: second output follows config pins
// - second output silent unless first runs
// - first selector bits 3:2 off,/1,/2,/4
// - pin mode: first output follows config pins
// - bit 1 selects single-ended reference input
// - bit 0 set enables synthesizer
// - 7-bit trim code sets oscillator frequency
// - calibration load replaces held trim code
// - trim readable and restorable by write
// - complete flag set when done or skipped
`timescale 1ns/1ps
`include "spot_defs.vh"

module spot_synth_override (
  input wire clk,
  input wire rst_n,
  // register access from the control port
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire [7:0] reg_wdata,
  input wire reg_rd,
  output reg [7:0] reg_rdata_q,
  output reg reg_rvalid_q,
  // configuration pins, asynchronous
  input wire synth_enable_pin,
  input wire reference_type_pin,
  input wire clock_config_pin_a,
  input wire clock_config_pin_b,
  // calibration engine
  input wire oscillator_cal_enable,
  input wire cal_running,
  input wire cal_finished,
  input wire cal_trim_load,
  input wire [6:0] cal_trim_value,
  // controls to the synthesizer
  output reg synth_enable_q,
  output reg single_ended_ref_input_q,
  output reg [1:0] first_divided_ref_output_q,
  output reg [1:0] second_divided_ref_output_q,
  output reg [6:0] oscillator_trim_code_q,
  output reg oscillator_cal_complete_q
);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // pin code {b,a}: 0 both off, 1 first /1, 2 both /1, 3 first /2, second /4
  function [1:0] pin_first_mode;
    input [1:0] cfg;
    begin
      case (cfg)
        2'h0: pin_first_mode = `SPOT_DIV_OFF;
        2'h1: pin_first_mode = `SPOT_DIV_BY1;
        2'h2: pin_first_mode = `SPOT_DIV_BY1;
        2'h3: pin_first_mode = `SPOT_DIV_BY2;
        default: pin_first_mode = `SPOT_DIV_OFF;
      endcase
    end
  endfunction

  function [1:0] pin_second_mode;
    input [1:0] cfg;
    begin
      case (cfg)
        2'h0: pin_second_mode = `SPOT_DIV_OFF;
        2'h1: pin_second_mode = `SPOT_DIV_OFF;
        2'h2: pin_second_mode = `SPOT_DIV_BY1;
        2'h3: pin_second_mode = `SPOT_DIV_BY4;
        default: pin_second_mode = `SPOT_DIV_OFF;
      endcase
    end
  endfunction

  function addr_hit;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      addr_hit = (addr == ofs);
    end
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  wire [3:0] pins_level;

  spot_pin_sync #(
    .WIDTH(4)
  ) u_pin_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pin_async({clock_config_pin_b, clock_config_pin_a, reference_type_pin,
                synth_enable_pin}),
    .pin_level_q(pins_level)
  );

  wire pin_syn_en = pins_level[0];
  wire pin_ref_type = pins_level[1];
  wire [1:0] pin_cfg = pins_level[3:2];

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg [7:0] override_q;
  reg [7:0] override_d;
  reg [6:0] trim_d;
  reg done_q;
  reg done_d;

  wire wr_override = reg_wr && addr_hit(reg_addr, `SPOT_OFS_OVERRIDE);
  wire wr_trim = reg_wr && addr_hit(reg_addr, `SPOT_OFS_TRIM);

  always @* begin
    override_d = override_q;
    if (wr_override) begin
      // reserved bits are stored as written; software keeps them zero
      // reserved bits kept
      override_d = reg_wdata;
    end
  end

  always @* begin
    trim_d = oscillator_trim_code_q;
    if (wr_trim) begin
      trim_d = reg_wdata[`SPOT_TRIM_MSB:`SPOT_TRIM_LSB];
    end
    // engine load wins
    // engine wins a same-cycle collision; writing mid-run is a misuse anyway
    if (cal_trim_load) begin
      trim_d = cal_trim_value;
    end
  end

  always @* begin
    done_d = done_q;
    // a new run clears the flag; finishing sets it, set wins
    if (cal_running) begin
      done_d = 1'b0;
    end
    if (cal_finished) begin
      done_d = 1'b1;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      override_q <= `SPOT_RST_OVERRIDE;
      oscillator_trim_code_q <= `SPOT_RST_TRIM;
      done_q <= 1'b0;
    end else begin
      override_q <= override_d;
      oscillator_trim_code_q <= trim_d;
      done_q <= done_d;
    end
  end

  // ----------------------------------------------------------------
  // control source selection
  // ----------------------------------------------------------------
  reg syn_en_d;
  reg ref_type_d;
  reg [1:0] first_d;
  reg [1:0] second_d;
  wire src_reg = override_q[`SPOT_BIT_SRC_SEL];

  always @* begin
    if (src_reg) begin
      syn_en_d = override_q[`SPOT_BIT_SYN_EN];
      ref_type_d = override_q[`SPOT_BIT_REF_TYPE];
      first_d = override_q[`SPOT_FIRST_MSB:`SPOT_FIRST_LSB];
      second_d = override_q[`SPOT_SECOND_MSB:`SPOT_SECOND_LSB];
    end else begin
      syn_en_d = pin_syn_en;
      ref_type_d = pin_ref_type;
      first_d = pin_first_mode(pin_cfg);
      second_d = pin_second_mode(pin_cfg);
    end
    if (first_d == `SPOT_DIV_OFF) begin
      second_d = `SPOT_DIV_OFF;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      synth_enable_q <= 1'b0;
      single_ended_ref_input_q <= 1'b0;
      first_divided_ref_output_q <= `SPOT_DIV_OFF;
      second_divided_ref_output_q <= `SPOT_DIV_OFF;
      oscillator_cal_complete_q <= 1'b0;
    end else begin
      synth_enable_q <= syn_en_d;
      single_ended_ref_input_q <= ref_type_d;
      first_divided_ref_output_q <= first_d;
      second_divided_ref_output_q <= second_d;
      oscillator_cal_complete_q <= done_d | ~oscillator_cal_enable;
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  // reads mid-run are not blocked; software must wait for complete
  reg [7:0] rdata_d;

  always @* begin
    rdata_d = 8'h00;
    case (reg_addr)
      `SPOT_OFS_OVERRIDE: rdata_d = override_q;
      `SPOT_OFS_TRIM: rdata_d = {1'b0, oscillator_trim_code_q};
      `SPOT_OFS_CAL_STATUS: rdata_d = {7'h00, oscillator_cal_complete_q};
      default: rdata_d = 8'h00;
    endcase
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_q <= 8'h00;
      reg_rvalid_q <= 1'b0;
    end else begin
      reg_rvalid_q <= reg_rd;
      if (reg_rd) begin
        reg_rdata_q <= rdata_d;
      end
    end
  end

endmodule // spot_synth_override

// *** shared/spot_defs.vh ***
/*
  constants for the synthesizer pin override and oscillator trim block:
  register offsets, field positions, reset values and divide-mode codes.
  assumes it is included by its bare name from design and bench files.
*/
`ifndef SPOT_DEFS_VH
`define SPOT_DEFS_VH

// ----------------------------------------------------------------
// register offsets (8-bit control port address space)
// ----------------------------------------------------------------
`define SPOT_OFS_OVERRIDE 8'h58
`define SPOT_OFS_TRIM 8'h59
`define SPOT_OFS_CAL_STATUS 8'h5e

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define SPOT_RST_OVERRIDE 8'h00
`define SPOT_RST_TRIM 7'h00

// ----------------------------------------------------------------
// override register fields
// ----------------------------------------------------------------
`define SPOT_BIT_SRC_SEL 7
`define SPOT_BIT_RSVD6 6
`define SPOT_SECOND_MSB 5
`define SPOT_SECOND_LSB 4
`define SPOT_FIRST_MSB 3
`define SPOT_FIRST_LSB 2
`define SPOT_BIT_REF_TYPE 1
`define SPOT_BIT_SYN_EN 0

// ----------------------------------------------------------------
// trim register and status fields
// ----------------------------------------------------------------
`define SPOT_TRIM_MSB 6
`define SPOT_TRIM_LSB 0
`define SPOT_TRIM_W 7
`define SPOT_BIT_CAL_DONE 0

// ----------------------------------------------------------------
// divided-reference output mode codes
// ----------------------------------------------------------------
`define SPOT_DIV_OFF 2'h0
`define SPOT_DIV_BY1 2'h1
`define SPOT_DIV_BY2 2'h2
`define SPOT_DIV_BY4 2'h3

// ----------------------------------------------------------------
// pin synchroniser depth
// ----------------------------------------------------------------
`define SPOT_SYNC_STAGES 3

`endif

// *** test/spot_synth_override_asserts.sv ***
/* checker for spot_synth_override, bound into every instance.
   assumes one clock domain and the two-edge write walk of the override. */
`timescale 1ns/1ps
`include "spot_defs.vh"
module spot_synth_override_asserts (
  input wire clk,
  input wire rst_n,
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire [7:0] reg_wdata,
  input wire reg_rd,
  input wire [7:0] reg_rdata_q,
  input wire reg_rvalid_q,
  input wire oscillator_cal_enable,
  input wire cal_finished,
  input wire cal_trim_load,
  input wire [6:0] cal_trim_value,
  input wire synth_enable_q,
  input wire single_ended_ref_input_q,
  input wire [1:0] first_divided_ref_output_q,
  input wire [1:0] second_divided_ref_output_q,
  input wire [6:0] oscillator_trim_code_q,
  input wire oscillator_cal_complete_q
);
  // ------------------------------------------------------------
  // override write sequences
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence ovr_wr;
    reg_wr && reg_addr == `SPOT_OFS_OVERRIDE && reg_wdata[7];
  endsequence
  // a second write would move the outputs again, so wait one quiet cycle
  sequence ovr_set;
    ovr_wr ##1 !(reg_wr && reg_addr == `SPOT_OFS_OVERRIDE);
  endsequence
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  enable_reg_a:
    assert property (ovr_set |=> synth_enable_q == $past(reg_wdata[0], 2) &&
      single_ended_ref_input_q == $past(reg_wdata[1], 2)) else $error("enable or ref");
  first_mode_a:
    assert property (ovr_set |=> first_divided_ref_output_q == $past(reg_wdata[3:2], 2))
      else $error("first mode");
  second_mode_a:
    assert property (ovr_set |=> second_divided_ref_output_q ==
      ($past(reg_wdata[3:2], 2) == 2'h0 ? 2'h0 : $past(reg_wdata[5:4], 2)))
      else $error("second mode");
  second_gate_a:
    assert property (first_divided_ref_output_q == 2'h0 |-> second_divided_ref_output_q == 2'h0)
      else $error("second runs alone");
  rd_answer_a:
    assert property (reg_rd |=> reg_rvalid_q) else $error("read answer missing");
  trim_read_a:
    assert property (reg_rd && reg_addr == `SPOT_OFS_TRIM |=>
      reg_rdata_q == {1'b0, $past(oscillator_trim_code_q)}) else $error("trim read");
  trim_write_a:
    assert property (reg_wr && reg_addr == `SPOT_OFS_TRIM && !cal_trim_load |=>
      oscillator_trim_code_q == $past(reg_wdata[6:0])) else $error("trim write");
  trim_load_a:
    assert property (cal_trim_load |=> oscillator_trim_code_q == $past(cal_trim_value))
      else $error("trim load");
  cal_skip_a:
    assert property (!oscillator_cal_enable |=> oscillator_cal_complete_q)
      else $error("skip not complete");
  cal_done_a:
    assert property (cal_finished |=> ##[0:1] oscillator_cal_complete_q)
      else $error("done not complete");
endmodule // spot_synth_override_asserts
bind spot_synth_override spot_synth_override_asserts u_chk (
  .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
  .reg_rvalid_q(reg_rvalid_q), .oscillator_cal_enable(oscillator_cal_enable),
  .cal_finished(cal_finished), .cal_trim_load(cal_trim_load),
  .cal_trim_value(cal_trim_value), .synth_enable_q(synth_enable_q),
  .single_ended_ref_input_q(single_ended_ref_input_q),
  .first_divided_ref_output_q(first_divided_ref_output_q),
  .second_divided_ref_output_q(second_divided_ref_output_q),
  .oscillator_trim_code_q(oscillator_trim_code_q),
  .oscillator_cal_complete_q(oscillator_cal_complete_q)
);

// *** test/synth_pin_override_and_trim_tb.sv ***
/* bench for spot_synth_override: pin and register control, trim, status.
   assumes spot_defs.vh on the include path and the checker bound in. */
`timescale 1ns/1ps
`include "spot_defs.vh"
module synth_pin_override_and_trim_tb;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg [7:0] reg_addr = 8'h00;
  reg [7:0] reg_wdata = 8'h00;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg synth_enable_pin = 1'b0, reference_type_pin = 1'b0;
  reg clock_config_pin_a = 1'b0, clock_config_pin_b = 1'b0;
  reg oscillator_cal_enable = 1'b1, cal_running = 1'b0, cal_finished = 1'b0;
  reg cal_trim_load = 1'b0;
  reg [6:0] cal_trim_value = 7'h00;
  wire [7:0] reg_rdata_q;
  wire reg_rvalid_q, synth_enable_q, single_ended_ref_input_q, oscillator_cal_complete_q;
  wire [1:0] first_divided_ref_output_q, second_divided_ref_output_q;
  wire [6:0] oscillator_trim_code_q;
  integer num_errors = 0;
  integer checks = 0;
  integer i;
  reg [1:0] ea, eb;
  spot_synth_override u_dut (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
    .reg_rvalid_q(reg_rvalid_q), .synth_enable_pin(synth_enable_pin),
    .reference_type_pin(reference_type_pin), .clock_config_pin_a(clock_config_pin_a),
    .clock_config_pin_b(clock_config_pin_b), .oscillator_cal_enable(oscillator_cal_enable),
    .cal_running(cal_running), .cal_finished(cal_finished), .cal_trim_load(cal_trim_load),
    .cal_trim_value(cal_trim_value), .synth_enable_q(synth_enable_q),
    .single_ended_ref_input_q(single_ended_ref_input_q),
    .first_divided_ref_output_q(first_divided_ref_output_q),
    .second_divided_ref_output_q(second_divided_ref_output_q),
    .oscillator_trim_code_q(oscillator_trim_code_q),
    .oscillator_cal_complete_q(oscillator_cal_complete_q)
  );
  always #10 clk = ~clk;
  // ------------------------------------------------------------
  // access tasks
  // ------------------------------------------------------------
  task chk(input [7:0] seen, input [7:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  // inputs move 1 ns after the edge so the dut never races the bench
  task cyc(input integer n);
    begin
      repeat (n) @(posedge clk);
      #1;
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      cyc(1);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      cyc(1);
      reg_wr = 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [7:0] exp);
    begin
      cyc(1);
      reg_addr = a;
      reg_rd = 1'b1;
      cyc(1);
      reg_rd = 1'b0;
      chk({7'h00, reg_rvalid_q}, 8'h01);
      chk(reg_rdata_q, exp);
    end
  endtask
  task test_done;
    begin
      $display("checks=%0d errors=%0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    cyc(6);
    rst_n = 1'b1;
    rd(`SPOT_OFS_OVERRIDE, 8'h00);
    rd(`SPOT_OFS_CAL_STATUS, 8'h00);
    wr(8'h10, 8'hff);
    rd(8'h10, 8'h00);
    $display("test reset done");
    wr(`SPOT_OFS_OVERRIDE, 8'h3f);
    for (i = 0; i < 16; i = i + 1) begin
      {clock_config_pin_b, clock_config_pin_a, reference_type_pin, synth_enable_pin} = i[3:0];
      cyc(8);
      case (i[3:2])
        0: {ea, eb} = 4'h0;
        1: {ea, eb} = 4'h4;
        2: {ea, eb} = 4'h5;
        default: {ea, eb} = 4'hb;
      endcase
      chk({6'h00, first_divided_ref_output_q}, {6'h00, ea});
      chk({6'h00, second_divided_ref_output_q}, {6'h00, eb});
      chk({6'h00, single_ended_ref_input_q, synth_enable_q}, {6'h00, i[1:0]});
    end
    $display("test pins done");
    for (i = 0; i < 16; i = i + 1) begin
      wr(`SPOT_OFS_OVERRIDE, {2'h2, i[3:0], i[0], ~i[1]});
      cyc(2);
      eb = (i[1:0] == 2'h0) ? 2'h0 : i[3:2];
      chk({6'h00, first_divided_ref_output_q}, {6'h00, i[1:0]});
      chk({6'h00, second_divided_ref_output_q}, {6'h00, eb});
      chk({6'h00, single_ended_ref_input_q, synth_enable_q}, {6'h00, i[0], ~i[1]});
    end
    rd(`SPOT_OFS_OVERRIDE, 8'hbe);
    $display("test override done");
    // calibration skipped, so trim access is safe
    oscillator_cal_enable = 1'b0;
    wr(`SPOT_OFS_TRIM, 8'h7f);
    rd(`SPOT_OFS_TRIM, 8'h7f);
    cal_trim_value = 7'h2a;
    cal_trim_load = 1'b1;
    cyc(1);
    cal_trim_load = 1'b0;
    chk({1'b0, oscillator_trim_code_q}, 8'h2a);
    rst_n = 1'b0;
    cyc(2);
    rst_n = 1'b1;
    chk({1'b0, oscillator_trim_code_q}, 8'h00);
    wr(`SPOT_OFS_TRIM, 8'h2a);
    rd(`SPOT_OFS_TRIM, 8'h2a);
    $display("test trim done");
    oscillator_cal_enable = 1'b1;
    cal_running = 1'b1;
    cyc(1);
    cal_running = 1'b0;
    cyc(1);
    chk({7'h00, oscillator_cal_complete_q}, 8'h00);
    cal_finished = 1'b1;
    cyc(1);
    cal_finished = 1'b0;
    cyc(1);
    chk({7'h00, oscillator_cal_complete_q}, 8'h01);
    rd(`SPOT_OFS_CAL_STATUS, 8'h01);
    cal_running = 1'b1;
    oscillator_cal_enable = 1'b0;
    cyc(2);
    chk({7'h00, oscillator_cal_complete_q}, 8'h01);
    // a running engine has cleared the flag set earlier
    oscillator_cal_enable = 1'b1;
    cyc(2);
    chk({7'h00, oscillator_cal_complete_q}, 8'h00);
    // finish and running in one cycle: set wins
    cal_finished = 1'b1;
    cyc(1);
    cal_finished = 1'b0;
    cal_running = 1'b0;
    cyc(1);
    chk({7'h00, oscillator_cal_complete_q}, 8'h01);
    $display("test calibration done");
    test_done;
  end
  // whole run is well under 1000 cycles
  initial begin
    #40000;
    num_errors = num_errors + 1;
    test_done;
  end
endmodule // synth_pin_override_and_trim_tb
